// [rtl/dcf_pkg.sv]
// ---------------------------------------------------------------------------
// shared constants and carriers of the converter control block
// ---------------------------------------------------------------------------
package dcf_pkg;

  // ---------------------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10; // 100 mhz system clock
  localparam int BANK_BUSY_NS = 600; // busy after a bank select write
  localparam int BANK_BUSY_CYC = (BANK_BUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CALC_BUSY_NS = 1500; // busy after a code, gain or offset write
  localparam int CALC_BUSY_CYC = (CALC_BUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BUSY_CNT_W = 8; // width of the busy counter

  // ---------------------------------------------------------------------------
  // command word mode field
  // ---------------------------------------------------------------------------
  localparam logic [1:0] MODE_SPECIAL = 2'h0; // special function
  localparam logic [1:0] MODE_GAIN = 2'h1; // gain word
  localparam logic [1:0] MODE_OFFSET = 2'h2; // offset word
  localparam logic [1:0] MODE_INPUT = 2'h3; // channel code word

  // ---------------------------------------------------------------------------
  // special function codes
  // ---------------------------------------------------------------------------
  localparam logic [5:0] SF_CTRL = 6'h02; // control register write
  localparam logic [5:0] SF_READ = 6'h05; // readback request
  localparam logic [5:0] SF_MON = 6'h0c; // monitor_select write
  localparam logic [5:0] SF_GPIO = 6'h0d; // aux_pin_config write
  localparam logic [5:0] SF_BANK0 = 6'h10; // bank select, channels 0..7
  localparam logic [5:0] SF_BANK1 = 6'h11; // bank select, channels 8..15

  // ---------------------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------------------
  localparam int CTRL_PD_BIT = 0; // power-down
  localparam int CTRL_TEN_BIT = 1; // thermal protection enable
  localparam int CTRL_AB_BIT = 2; // input bank for code writes
  localparam int CTRL_TFLAG_BIT = 4; // thermal shutdown flag
  localparam int MON_EN_BIT = 5; // monitor_enable_bit
  localparam int MON_SRC_BIT = 4; // monitor_source_bit
  localparam int GPIO_DIR_BIT = 1; // gpio_direction_bit
  localparam int GPIO_LVL_BIT = 0; // gpio_level_bit

  // ---------------------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------------------
  localparam logic [5:0] MON_RST = 6'h00; // monitor disabled
  localparam logic [1:0] GPIO_RST = 2'h0; // pin is an input
  localparam logic [15:0] CODE_RST = 16'h0000; // code registers
  localparam logic [15:0] GAIN_RST = 16'hffff; // unity gain word
  localparam logic [15:0] OFFS_RST = 16'h8000; // mid-scale offset word
  localparam logic [3:0] SYNC_RST = 4'h4; // pins idle: load_outputs_n high

  // ---------------------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [1:0] mode; // command mode
    logic [5:0] addr; // address or special function code
    logic [15:0] data; // data field
  } dcf_cmd_t;

  typedef struct packed {
    logic data_format_select; // 1: two's complement codes
    logic load_outputs_n; // low loads outputs
    logic gpio_pin; // level on the general-purpose pin
    logic over_temp; // comparator says die too hot
  } dcf_pins_t;

endpackage

// [rtl/dcf_sync.sv]
`timescale 1ns/1ps
// ---------------------------------------------------------------------------
// three-stage pin synchroniser with agreement filter
// ---------------------------------------------------------------------------
module dcf_sync #(
  parameter int WIDTH = 4,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // raw pins and filtered levels
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] level_o
);

  typedef struct packed {
    logic [WIDTH-1:0] s1; // first stage, read only by s2
    logic [WIDTH-1:0] s2; // second stage
    logic [WIDTH-1:0] s3; // third stage
    logic [WIDTH-1:0] lvl; // accepted level
  } dcf_sync_st_t;

  dcf_sync_st_t st_ff;
  dcf_sync_st_t nxt_st;

  // shift and accept a bit only when stages two and three agree
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.s1 = async_i;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    for (int i = 0; i < WIDTH; i++)
    begin
      if (st_ff.s2[i] == st_ff.s3[i])
      begin
        nxt_st.lvl[i] = st_ff.s3[i];
      end
    end
  end

  // state register
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      st_ff <= {4{RST_VAL}};
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign level_o = st_ff.lvl;

endmodule

// [rtl/dcf_busy_timer.sv]
`timescale 1ns/1ps
// ---------------------------------------------------------------------------
// retriggerable busy counter
// ---------------------------------------------------------------------------
module dcf_busy_timer #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // start request and length in cycles
  input wire logic start_i,
  input wire logic [W-1:0] len_i,
  // counter running
  output logic busy_o
);

  typedef struct packed {
    logic [W-1:0] cnt; // cycles left
  } dcf_timer_st_t;

  dcf_timer_st_t st_ff;
  dcf_timer_st_t nxt_st;

  // a new start never shortens a running period
  always_comb
  begin
    nxt_st = st_ff;
    if (st_ff.cnt != '0)
    begin
      nxt_st.cnt = st_ff.cnt - 1'b1;
    end
    if (start_i && (len_i > nxt_st.cnt))
    begin
      nxt_st.cnt = len_i;
    end
  end

  // state register
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign busy_o = (st_ff.cnt != '0);

endmodule

// [rtl/dcf_top.sv]
`timescale 1ns/1ps
module dcf_top #(
  parameter int NCH = 16
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // decoded command words from the serial front end
  input wire logic cmd_valid_i,
  input wire dcf_pkg::dcf_cmd_t cmd_i,
  // readback
  output logic rd_valid_o,
  output logic [15:0] rd_data_o,
  // device pins
  input wire dcf_pkg::dcf_pins_t pins_i,
  output logic busy_n_o,
  // general-purpose pin
  output logic gpio_o,
  output logic gpio_oe_n_o,
  // monitor multiplexer control
  output logic mon_en_o,
  output logic mon_aux_o,
  output logic [3:0] mon_chan_o,
  // converter side
  output logic gnd_sel_o,
  output logic [NCH-1:0][15:0] dac_code_o,
  output logic [NCH-1:0][15:0] gain_o,
  output logic [NCH-1:0][15:0] offset_o
);

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic pd; // power-down bit
    logic therm_en; // thermal protection enable
    logic ab_sel; // input bank for code writes
    logic therm_flag; // thermal shutdown latched
    logic gnd; // outputs switched to ground level
    logic [5:0] mon; // monitor_select
    logic [1:0] gpio; // aux_pin_config
    logic gpio_oe_n; // pin drive enable, low drives
    logic [NCH-1:0] bank_sel; // output_source_select per channel
    logic [NCH-1:0][15:0] in_a; // input_reg_a
    logic [NCH-1:0][15:0] in_b; // input_reg_b
    logic [NCH-1:0][15:0] comp_a; // computed_reg_a
    logic [NCH-1:0][15:0] comp_b; // computed_reg_b
    logic [NCH-1:0][15:0] gain; // gain words
    logic [NCH-1:0][15:0] offs; // offset words
    logic [NCH-1:0][15:0] dac; // output registers
    logic [NCH-1:0] fresh_a; // computed_reg_a written since last load
    logic [NCH-1:0] fresh_b; // computed_reg_b written since last load
    logic load_pend; // load request seen while busy
    logic over_prev; // previous over-temperature level
    logic busy_n; // busy output
    logic rd_valid; // readback strobe
    logic [15:0] rd_data; // readback word
  } dcf_st_t;

  dcf_st_t st_ff;
  dcf_st_t nxt_st;

  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  // two's complement to straight binary by flipping the sign bit
  function automatic logic [15:0] to_bin(input logic [15:0] w, input logic twos);
    to_bin = {w[15] ^ twos, w[14:0]};
  endfunction

  // pins through the synchroniser
  logic [3:0] pin_lvl;
  dcf_pkg::dcf_pins_t pin_s;
  logic calc_start;
  logic bank_start;
  logic busy_calc;
  logic busy_bank;

  dcf_sync #(
    .WIDTH(4),
    .RST_VAL(dcf_pkg::SYNC_RST)
  ) u_sync (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .async_i(pins_i),
    .level_o(pin_lvl)
  );

  assign pin_s = dcf_pkg::dcf_pins_t'(pin_lvl);

  // recalculation busy period
  dcf_busy_timer #(
    .W(dcf_pkg::BUSY_CNT_W)
  ) u_calc_busy (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .start_i(calc_start),
    .len_i(dcf_pkg::BUSY_CNT_W'(dcf_pkg::CALC_BUSY_CYC)),
    .busy_o(busy_calc)
  );

  // bank select busy period
  dcf_busy_timer #(
    .W(dcf_pkg::BUSY_CNT_W)
  ) u_bank_busy (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .start_i(bank_start),
    .len_i(dcf_pkg::BUSY_CNT_W'(dcf_pkg::BANK_BUSY_CYC)),
    .busy_o(busy_bank)
  );

  // ---------------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------------
  always_comb
  begin
    logic [15:0] wd;
    logic [3:0] ch;
    logic is_sf;
    logic busy;
    logic load_go;
    logic therm_rise;
    wd = cmd_i.data;
    ch = cmd_i.addr[3:0];
    is_sf = cmd_valid_i && (cmd_i.mode == dcf_pkg::MODE_SPECIAL);
    busy = busy_calc || busy_bank;
    load_go = 1'b0;
    therm_rise = 1'b0;
    nxt_st = st_ff;
    nxt_st.rd_valid = 1'b0;
    calc_start = 1'b0;
    bank_start = 1'b0;

    // channel data writes
    if (cmd_valid_i)
    begin
      unique case (cmd_i.mode)
        dcf_pkg::MODE_INPUT:
        begin
          // code word honours the format pin
          wd = to_bin(cmd_i.data, pin_s.data_format_select);
          calc_start = 1'b1;
          if (st_ff.ab_sel)
          begin
            nxt_st.in_b[ch] = wd;
            nxt_st.comp_b[ch] = wd;
            nxt_st.fresh_b[ch] = 1'b1;
          end
          else
          begin
            nxt_st.in_a[ch] = wd;
            nxt_st.comp_a[ch] = wd;
            nxt_st.fresh_a[ch] = 1'b1;
          end
        end
        dcf_pkg::MODE_OFFSET:
        begin
          // offset word honours the format pin
          nxt_st.offs[ch] = to_bin(cmd_i.data, pin_s.data_format_select);
          calc_start = 1'b1;
          nxt_st.fresh_a[ch] = 1'b1;
          nxt_st.fresh_b[ch] = 1'b1;
        end
        dcf_pkg::MODE_GAIN:
        begin
          // gain word is always straight binary
          nxt_st.gain[ch] = cmd_i.data;
          calc_start = 1'b1;
          nxt_st.fresh_a[ch] = 1'b1;
          nxt_st.fresh_b[ch] = 1'b1;
        end
        dcf_pkg::MODE_SPECIAL:
        begin
          // special functions handled below
        end
      endcase
    end

    // special function writes, control words taken as straight binary
    if (is_sf)
    begin
      unique case (cmd_i.addr)
        dcf_pkg::SF_CTRL:
        begin
          nxt_st.pd = cmd_i.data[dcf_pkg::CTRL_PD_BIT];
          nxt_st.therm_en = cmd_i.data[dcf_pkg::CTRL_TEN_BIT];
          nxt_st.ab_sel = cmd_i.data[dcf_pkg::CTRL_AB_BIT];
          // flag leaves only when protection is switched off
          if (!cmd_i.data[dcf_pkg::CTRL_TEN_BIT])
          begin
            nxt_st.therm_flag = 1'b0;
          end
        end
        dcf_pkg::SF_MON:
        begin
          nxt_st.mon = cmd_i.data[5:0];
        end
        dcf_pkg::SF_GPIO:
        begin
          nxt_st.gpio = cmd_i.data[1:0];
        end
        dcf_pkg::SF_BANK0:
        begin
          // one word switches eight channels, no recalculation
          nxt_st.bank_sel[7:0] = cmd_i.data[7:0];
          bank_start = 1'b1;
        end
        dcf_pkg::SF_BANK1:
        begin
          nxt_st.bank_sel[15:8] = cmd_i.data[7:0];
          bank_start = 1'b1;
        end
        dcf_pkg::SF_READ:
        begin
          // readback of the register named by the low data bits
          nxt_st.rd_valid = 1'b1;
          nxt_st.rd_data = 16'h0000;
          unique case (cmd_i.data[5:0])
            dcf_pkg::SF_CTRL:
            begin
              nxt_st.rd_data[dcf_pkg::CTRL_PD_BIT] = st_ff.pd;
              nxt_st.rd_data[dcf_pkg::CTRL_TEN_BIT] = st_ff.therm_en;
              nxt_st.rd_data[dcf_pkg::CTRL_AB_BIT] = st_ff.ab_sel;
              nxt_st.rd_data[dcf_pkg::CTRL_TFLAG_BIT] = st_ff.therm_flag;
            end
            dcf_pkg::SF_MON:
            begin
              nxt_st.rd_data[5:0] = st_ff.mon;
            end
            dcf_pkg::SF_GPIO:
            begin
              nxt_st.rd_data[0] = pin_s.gpio_pin;
            end
            dcf_pkg::SF_BANK0:
            begin
              nxt_st.rd_data[7:0] = st_ff.bank_sel[7:0];
            end
            dcf_pkg::SF_BANK1:
            begin
              nxt_st.rd_data[7:0] = st_ff.bank_sel[15:8];
            end
            default:
            begin
              // unmapped register reads as zero
              nxt_st.rd_data = 16'h0000;
            end
          endcase
        end
        default:
        begin
          // unknown code ignored
        end
      endcase
    end

    // thermal shutdown on a rising comparator level, set beats clear
    nxt_st.over_prev = pin_s.over_temp;
    therm_rise = pin_s.over_temp && !st_ff.over_prev;
    if (therm_rise && st_ff.therm_en)
    begin
      nxt_st.therm_flag = 1'b1;
    end

    // ground outputs under power-down or shutdown, registers untouched
    nxt_st.gnd = nxt_st.pd || nxt_st.therm_flag;

    // pin drives only with the direction bit set
    nxt_st.gpio_oe_n = !nxt_st.gpio[dcf_pkg::GPIO_DIR_BIT];

    // load: stored while busy, level-held low keeps loading
    load_go = !busy && (st_ff.load_pend || !pin_s.load_outputs_n);
    nxt_st.load_pend = busy && (st_ff.load_pend || !pin_s.load_outputs_n);
    if (load_go)
    begin
      for (int i = 0; i < NCH; i++)
      begin
        if (st_ff.bank_sel[i])
        begin
          // only a freshly written selection reaches the output
          if (st_ff.fresh_b[i])
          begin
            nxt_st.dac[i] = st_ff.comp_b[i];
            nxt_st.fresh_b[i] = 1'b0;
          end
        end
        else if (st_ff.fresh_a[i])
        begin
          nxt_st.dac[i] = st_ff.comp_a[i];
          nxt_st.fresh_a[i] = 1'b0;
        end
      end
    end

    // busy output low while either period runs
    nxt_st.busy_n = !(busy || calc_start || bank_start);
  end

  // ---------------------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      // control bits cleared, pin input, monitor off
      st_ff <= '0;
      st_ff.mon <= dcf_pkg::MON_RST;
      st_ff.gpio <= dcf_pkg::GPIO_RST;
      st_ff.gpio_oe_n <= 1'b1;
      st_ff.busy_n <= 1'b1;
      st_ff.gain <= {NCH{dcf_pkg::GAIN_RST}};
      st_ff.offs <= {NCH{dcf_pkg::OFFS_RST}};
      st_ff.dac <= {NCH{dcf_pkg::CODE_RST}};
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // ---------------------------------------------------------------------------
  // outputs, all from flip-flops
  // ---------------------------------------------------------------------------
  assign rd_valid_o = st_ff.rd_valid;
  assign rd_data_o = st_ff.rd_data;
  assign busy_n_o = st_ff.busy_n;
  assign gpio_o = st_ff.gpio[dcf_pkg::GPIO_LVL_BIT];
  assign gpio_oe_n_o = st_ff.gpio_oe_n;
  assign mon_en_o = st_ff.mon[dcf_pkg::MON_EN_BIT];
  assign mon_aux_o = st_ff.mon[dcf_pkg::MON_SRC_BIT];
  assign mon_chan_o = st_ff.mon[3:0];
  assign gnd_sel_o = st_ff.gnd;
  assign dac_code_o = st_ff.dac;
  assign gain_o = st_ff.gain;
  assign offset_o = st_ff.offs;

endmodule

// [verif/dcf_top_monitor.sv]
`timescale 1ns/1ps
// ------------------------------------------
// port checks of the converter control block
// ------------------------------------------
module dcf_top_monitor #(
  parameter int NCH = 16
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // command and readback
  input wire logic cmd_valid_i,
  input wire dcf_pkg::dcf_cmd_t cmd_i,
  input wire logic rd_valid_o,
  input wire logic [15:0] rd_data_o,
  // device side outputs
  input wire logic busy_n_o,
  input wire logic gpio_o,
  input wire logic gpio_oe_n_o,
  input wire logic mon_en_o,
  input wire logic mon_aux_o,
  input wire logic [3:0] mon_chan_o,
  input wire logic gnd_sel_o,
  input wire logic [NCH-1:0][15:0] dac_code_o
);
  logic sp_w; // special function word taken
  logic ctrl_w; // control register write taken
  assign sp_w = cmd_valid_i && (cmd_i.mode == dcf_pkg::MODE_SPECIAL);
  assign ctrl_w = sp_w && (cmd_i.addr == dcf_pkg::SF_CTRL);

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);

  a_gpio_drive: assert property (
    sp_w && cmd_i.addr == dcf_pkg::SF_GPIO |=> gpio_oe_n_o == !$past(cmd_i.data[1])
    && (gpio_oe_n_o || gpio_o == $past(cmd_i.data[0]))) else $error("gpio setting lost");
  a_mon_route: assert property (
    sp_w && cmd_i.addr == dcf_pkg::SF_MON
    |=> {mon_en_o, mon_aux_o, mon_chan_o} == $past(cmd_i.data[5:0]))
    else $error("monitor select not applied");
  a_bank_busy: assert property (
    sp_w && (cmd_i.addr == dcf_pkg::SF_BANK0 || cmd_i.addr == dcf_pkg::SF_BANK1)
    |=> !busy_n_o [*8]) else $error("busy missing after bank write");
  a_calc_busy: assert property (
    cmd_valid_i && cmd_i.mode != dcf_pkg::MODE_SPECIAL |=> !busy_n_o [*8])
    else $error("busy missing after code write");
  a_read_answer: assert property (
    sp_w && cmd_i.addr == dcf_pkg::SF_READ |=> rd_valid_o)
    else $error("readback word missing");
  a_pin_read: assert property (
    sp_w && cmd_i.addr == dcf_pkg::SF_READ && cmd_i.data[5:0] == dcf_pkg::SF_GPIO
    |=> rd_data_o[15:1] == 15'h0000) else $error("pin readback upper bits set");
  a_pd_ground: assert property (
    ctrl_w && cmd_i.data[0] |=> gnd_sel_o) else $error("power-down did not ground");
  a_ground_hold: assert property (
    $fell(gnd_sel_o) |-> $past(ctrl_w)) else $error("ground left without control write");
  a_load_idle: assert property (
    !$stable(dac_code_o) |-> busy_n_o || $past(busy_n_o))
    else $error("output register changed while busy");
endmodule

// [verif/dcf_host_model.sv]
`timescale 1ns/1ps
// ------------------------------------------
// host side of the command port
// ------------------------------------------
module dcf_host_model (
  // clock
  input wire logic clk_i,
  // command words toward the device
  output dcf_pkg::dcf_cmd_t cmd_o,
  output logic cmd_valid_o,
  // readback from the device
  input wire logic rd_valid_i,
  input wire logic [15:0] rd_data_i
);
  initial
  begin
    cmd_valid_o = 1'b0;
    cmd_o = '0;
  end

  // one word for one edge, then the bus shows the inverse
  task automatic send(input logic [1:0] mode, input logic [5:0] addr, input logic [15:0] data);
    @(posedge clk_i);
    cmd_valid_o <= 1'b1;
    cmd_o <= {mode, addr, data};
    @(posedge clk_i);
    cmd_valid_o <= 1'b0;
    cmd_o <= ~{mode, addr, data};
  endtask

  // readback request, answer awaited a few edges
  task automatic read(input logic [5:0] code, output logic [15:0] data);
    int n;
    send(dcf_pkg::MODE_SPECIAL, dcf_pkg::SF_READ, {10'h000, code});
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end while (rd_valid_i !== 1'b1 && n < 4);
    data = (rd_valid_i === 1'b1) ? rd_data_i : 16'hxxxx;
  endtask
endmodule

// [verif/dcf_top_tb.sv]
`timescale 1ns/1ps
// ------------------------------------------
// bench of the converter control block
// ------------------------------------------
module dcf_top_tb;
  localparam int NCH = 16;
  logic clk_i;
  logic resetn_i;
  logic cmd_valid_i;
  dcf_pkg::dcf_cmd_t cmd_i;
  logic rd_valid_o;
  logic [15:0] rd_data_o;
  dcf_pkg::dcf_pins_t pins_i;
  logic busy_n_o, gpio_o, gpio_oe_n_o, mon_en_o, mon_aux_o, gnd_sel_o;
  logic [3:0] mon_chan_o;
  logic [NCH-1:0][15:0] dac_code_o, gain_o, offset_o;
  logic fmt, ld_n, ext_pin, hot; // bench pin levels
  logic [15:0] v; // last readback word
  logic [5:0] mon_tab [6] = '{6'h00, 6'h20, 6'h2f, 6'h30, 6'h31, 6'h1f};
  int fail_count = 0;
  int n_compared = 0;

  // shared pin: device level while it drives, bench level otherwise
  assign pins_i = {fmt, ld_n, gpio_oe_n_o ? ext_pin : gpio_o, hot};

  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  dcf_top #(.NCH(NCH)) dcf_top_i (
    .clk_i(clk_i), .resetn_i(resetn_i), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i),
    .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o), .pins_i(pins_i), .busy_n_o(busy_n_o),
    .gpio_o(gpio_o), .gpio_oe_n_o(gpio_oe_n_o), .mon_en_o(mon_en_o), .mon_aux_o(mon_aux_o),
    .mon_chan_o(mon_chan_o), .gnd_sel_o(gnd_sel_o), .dac_code_o(dac_code_o),
    .gain_o(gain_o), .offset_o(offset_o));

  dcf_host_model dcf_host_model_i (
    .clk_i(clk_i), .cmd_o(cmd_i), .cmd_valid_o(cmd_valid_i),
    .rd_valid_i(rd_valid_o), .rd_data_i(rd_data_o));

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
      fail_count++;
    end
  endtask

  // special word, then one edge so its effect is visible
  task automatic sp(input logic [5:0] code, input logic [15:0] data);
    dcf_host_model_i.send(dcf_pkg::MODE_SPECIAL, code, data);
    @(posedge clk_i);
  endtask

  task automatic rd(input logic [5:0] code);
    dcf_host_model_i.read(code, v);
  endtask

  // hold the load pin low long enough to pass the synchroniser
  task automatic pulse_ld;
    ld_n <= 1'b0;
    repeat (4) @(posedge clk_i);
    ld_n <= 1'b1;
    repeat (8) @(posedge clk_i);
  endtask

  // wait for busy to end, then pulse the load pin
  task automatic settle;
    int n;
    n = 0;
    @(posedge clk_i);
    while (busy_n_o !== 1'b1 && n < 300)
    begin
      @(posedge clk_i);
      n++;
    end
    check("busy end", 16'(n < 300), 16'h0001);
    pulse_ld();
  endtask

  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // watchdog: the tests need about 700 cycles
  initial
  begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    stop_test();
  end

  initial
  begin
    resetn_i = 1'b0;
    fmt = 1'b0;
    ld_n = 1'b1;
    ext_pin = 1'b0;
    hot = 1'b0;
    repeat (2) @(posedge clk_i);
    resetn_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    check("reset outs", 16'({gpio_oe_n_o, mon_en_o, gnd_sel_o, busy_n_o}), 16'h0009);
    rd(dcf_pkg::SF_CTRL);
    check("reset ctrl", v, 16'h0000);
    $display("reset test done");
    // codes in both formats, both input banks
    fmt <= 1'b1;
    repeat (6) @(posedge clk_i);
    dcf_host_model_i.send(dcf_pkg::MODE_INPUT, 6'h03, 16'h1234);
    dcf_host_model_i.send(dcf_pkg::MODE_GAIN, 6'h03, 16'h1234);
    dcf_host_model_i.send(dcf_pkg::MODE_OFFSET, 6'h03, 16'h1234);
    fmt <= 1'b0;
    repeat (6) @(posedge clk_i);
    dcf_host_model_i.send(dcf_pkg::MODE_INPUT, 6'h04, 16'h1234);
    dcf_host_model_i.send(dcf_pkg::MODE_INPUT, 6'h08, 16'h0808);
    dcf_host_model_i.send(dcf_pkg::MODE_INPUT, 6'h09, 16'h1111);
    sp(dcf_pkg::SF_CTRL, 16'h0004);
    dcf_host_model_i.send(dcf_pkg::MODE_INPUT, 6'h09, 16'h2222);
    sp(dcf_pkg::SF_CTRL, 16'h0000);
    settle();
    check("code twos", dac_code_o[3], 16'h9234);
    check("code binary", dac_code_o[4], 16'h1234);
    check("gain word", gain_o[3], 16'h1234);
    check("offset word", offset_o[3], 16'h9234);
    check("bank a", dac_code_o[9], 16'h1111);
    $display("format test done");
    // toggle between banks without new codes
    sp(dcf_pkg::SF_BANK0, 16'h0000);
    sp(dcf_pkg::SF_BANK1, 16'h0002);
    settle();
    check("bank b", dac_code_o[9], 16'h2222);
    check("neighbour a", dac_code_o[8], 16'h0808);
    sp(dcf_pkg::SF_BANK1, 16'h0000);
    settle();
    check("stale a", dac_code_o[9], 16'h2222);
    // load pulse during busy is stored and applied when busy ends
    dcf_host_model_i.send(dcf_pkg::MODE_INPUT, 6'h05, 16'h5555);
    pulse_ld();
    check("load held", dac_code_o[5], 16'h0000);
    repeat (160) @(posedge clk_i);
    check("load stored", dac_code_o[5], 16'h5555);
    $display("toggle test done");
    for (int i = 0; i < 6; i++)
    begin
      sp(dcf_pkg::SF_MON, {10'h000, mon_tab[i]});
      check("monitor", 16'({mon_en_o, mon_aux_o, mon_chan_o}), 16'(mon_tab[i]));
    end
    $display("monitor test done");
    sp(dcf_pkg::SF_GPIO, 16'h0003);
    check("gpio high", 16'({gpio_oe_n_o, gpio_o}), 16'h0001);
    repeat (6) @(posedge clk_i);
    rd(dcf_pkg::SF_GPIO);
    check("pin driven", v, 16'h0001);
    sp(dcf_pkg::SF_GPIO, 16'h0002);
    check("gpio low", 16'({gpio_oe_n_o, gpio_o}), 16'h0000);
    sp(dcf_pkg::SF_GPIO, 16'h0000);
    check("gpio input", 16'(gpio_oe_n_o), 16'h0001);
    repeat (6) @(posedge clk_i);
    rd(dcf_pkg::SF_GPIO);
    check("pin low", v, 16'h0000);
    ext_pin <= 1'b1;
    repeat (6) @(posedge clk_i);
    rd(dcf_pkg::SF_GPIO);
    check("pin high", v, 16'h0001);
    rd(6'h3f);
    check("unmapped", v, 16'h0000);
    $display("gpio test done");
    sp(dcf_pkg::SF_CTRL, 16'h0001);
    check("pd on", 16'(gnd_sel_o), 16'h0001);
    check("pd keeps", dac_code_o[9], 16'h2222);
    sp(dcf_pkg::SF_CTRL, 16'h0000);
    check("pd off", 16'(gnd_sel_o), 16'h0000);
    $display("power-down test done");
    hot <= 1'b1;
    repeat (8) @(posedge clk_i);
    check("hot unarmed", 16'(gnd_sel_o), 16'h0000);
    hot <= 1'b0;
    sp(dcf_pkg::SF_CTRL, 16'h0002);
    repeat (6) @(posedge clk_i);
    hot <= 1'b1;
    repeat (8) @(posedge clk_i);
    check("shutdown", 16'(gnd_sel_o), 16'h0001);
    hot <= 1'b0;
    repeat (8) @(posedge clk_i);
    rd(dcf_pkg::SF_CTRL);
    check("flag set", v, 16'h0012);
    check("still down", 16'(gnd_sel_o), 16'h0001);
    sp(dcf_pkg::SF_CTRL, 16'h0000);
    check("released", 16'(gnd_sel_o), 16'h0000);
    rd(dcf_pkg::SF_CTRL);
    check("flag clear", v, 16'h0000);
    $display("thermal test done");
    stop_test();
  end
endmodule

bind dcf_top dcf_top_monitor #(.NCH(NCH)) dcf_top_monitor_i (
  .clk_i(clk_i), .resetn_i(resetn_i), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i),
  .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o), .busy_n_o(busy_n_o), .gpio_o(gpio_o),
  .gpio_oe_n_o(gpio_oe_n_o), .mon_en_o(mon_en_o), .mon_aux_o(mon_aux_o),
  .mon_chan_o(mon_chan_o), .gnd_sel_o(gnd_sel_o), .dac_code_o(dac_code_o));
